// file: src/apsf_framer.sv
// position serial framer top with its character fifo
`timescale 1ns/1ps

module apsf_fifo #(
  parameter int W = 7,
  parameter int D = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem      [D];
  logic [W-1:0]  next_mem [D];
  logic [AW-1:0] wr, rd, next_wr, next_rd;
  logic [AW:0]   cnt, next_cnt;
  logic          push, pop;

  assign in_ready_o  = (cnt != (AW+1)'(D));
  assign out_valid_o = (cnt != '0);
  assign out_data_o  = mem[rd];

  always_comb begin
    push     = in_valid_i & in_ready_o;
    pop      = out_valid_o & out_ready_i;
    next_mem = mem;
    next_wr  = wr;
    next_rd  = rd;
    if (push) begin
      next_mem[wr] = in_data_i;
      next_wr      = (wr == AW'(D-1)) ? '0 : wr + 1'b1;
    end
    if (pop) begin
      next_rd = (rd == AW'(D-1)) ? '0 : rd + 1'b1;
    end
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < D; i++) mem[i] <= '0;
      wr  <= '0;
      rd  <= '0;
      cnt <= '0;
    end else if (ce_i) begin
      mem <= next_mem;
      wr  <= next_wr;
      rd  <= next_rd;
      cnt <= next_cnt;
    end
  end
endmodule

module apsf_framer #(
  parameter int FRAME_CYC_P = apsf_pkg::FRAME_CYC,
  parameter int BIT_CYC_P   = apsf_pkg::BIT_CYC
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  input  wire apsf_pkg::apsf_sel_t zphase_output_select_i,
  input  wire logic                encoder_type_select_i,
  input  wire logic [31:0]         abs_position_i,
  input  wire logic [31:0]         inc_position_i,
  input  wire logic                zphase_pulse_i,
  input  wire logic                second_gear_select_i,
  input  wire apsf_pkg::apsf_gear_t gear1_i,
  input  wire apsf_pkg::apsf_gear_t gear2_i,
  output logic                     zphase_line_pos_o,
  output logic                     zphase_line_neg_o,
  output logic                     data_invalid_o
);
  import apsf_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_DIV, S_BUILD} apsf_state_t;

  apsf_state_t state, next_state;
  logic [21:0] frame_cnt, next_frame_cnt;
  apsf_pos_t   smp, next_smp;
  logic [47:0] quo, next_quo;
  logic [16:0] rem, next_rem, trial;
  logic [5:0]  div_cnt, next_div_cnt;
  logic [3:0]  idx, next_idx, dig, next_dig;
  logic [17:0] val, next_val;
  logic        invalid, next_invalid;
  apsf_gear_t  gear;
  apsf_pos_t   src;
  logic [31:0] raw;
  logic        is_digit, push, in_ready;
  logic [19:0] pw;
  logic [6:0]  ch, fifo_data;
  logic        fifo_valid, pop;

  function automatic logic [19:0] pow10(input logic [3:0] i);
    unique case (i)
      4'h8:               pow10 = 20'hf4240;
      4'h9:               pow10 = 20'h186a0;
      4'h2, 4'ha:         pow10 = 20'h02710;
      4'h3, 4'hb:         pow10 = 20'h003e8;
      4'h4, 4'hc:         pow10 = 20'h00064;
      4'h5, 4'hd:         pow10 = 20'h0000a;
      default:            pow10 = 20'h00001;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // frame capture, gearing and character build
  always_comb begin
    gear = second_gear_select_i ? gear2_i : gear1_i; // RQ8
    raw  = encoder_type_select_i ? abs_position_i : inc_position_i; // RQ6
    src.neg = raw[31];
    src.mag = raw[31] ? (~raw + 32'h1) : raw;
    is_digit = (idx >= 4'h2 && idx <= 4'h6) || (idx >= 4'h8 && idx <= 4'he);
    pw = pow10(idx);
    unique case (idx)
      IDX_HEAD:  ch = CH_HEAD; // RQ1
      IDX_SIGN:  ch = smp.neg ? CH_MINUS : CH_PLUS; // RQ2
      IDX_DELIM: ch = CH_DELIM;
      IDX_LAST:  ch = CH_CR; // RQ1
      default:   ch = CH_ZERO + {3'h0, dig};
    endcase
    trial          = {rem[15:0], quo[47]};
    next_state     = state;
    next_frame_cnt = (frame_cnt == '0) ? 22'(FRAME_CYC_P - 1) : frame_cnt - 22'h1; // RQ10
    next_smp       = smp;
    next_quo       = quo;
    next_rem       = rem;
    next_div_cnt   = div_cnt;
    next_idx       = idx;
    next_dig       = dig;
    next_val       = val;
    next_invalid   = invalid;
    push           = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (frame_cnt == '0 && zphase_output_select_i != APSF_SEL_PULSE) begin // RQ5
          next_smp     = src; // RQ11
          next_idx     = IDX_HEAD;
          next_dig     = '0;
          next_val     = {1'b0, src.mag[31:TURN_BITS]};
          next_invalid = (src.mag[31:TURN_BITS] > MULTI_MAX);
          if (zphase_output_select_i == APSF_SEL_GEARED) begin
            next_quo     = {16'h0000, src.mag} * {32'h00000000, gear.den}; // RQ7
            next_rem     = '0;
            next_div_cnt = '0;
            next_invalid = (gear.den > gear.num) || (gear.num == '0); // RQ9
            next_state   = S_DIV;
          end else begin
            next_state = S_BUILD;
          end
        end
      end
      S_DIV: begin
        if (div_cnt == 6'(DIV_STEPS)) begin
          next_smp.mag = quo[31:0]; // RQ7
          next_val     = {1'b0, quo[31:TURN_BITS]};
          next_invalid = invalid | (|quo[47:32]) | (quo[31:TURN_BITS] > MULTI_MAX); // RQ9
          next_state   = S_BUILD;
        end else begin
          next_quo     = {quo[46:0], 1'b0};
          next_rem     = trial;
          if (trial >= {1'b0, gear.num}) begin
            next_rem    = trial - {1'b0, gear.num};
            next_quo[0] = 1'b1;
          end
          next_div_cnt = div_cnt + 6'h1;
        end
      end
      S_BUILD: begin
        if (is_digit && {2'b00, val} >= pw) begin
          next_val = val - pw[17:0];
          next_dig = dig + 4'h1;
        end else if (in_ready) begin
          push     = 1'b1;
          next_idx = idx + 4'h1;
          next_dig = '0;
          if (idx == IDX_DELIM) next_val = {1'b0, smp.mag[TURN_BITS-1:0], 2'b00}; // RQ3
          if (idx == IDX_LAST) next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= S_IDLE;
      frame_cnt <= '0;
      smp       <= '0;
      quo       <= '0;
      rem       <= '0;
      div_cnt   <= '0;
      idx       <= '0;
      dig       <= '0;
      val       <= '0;
      invalid   <= 1'b0;
    end else if (ce_i) begin
      state     <= next_state;
      frame_cnt <= next_frame_cnt;
      smp       <= next_smp;
      quo       <= next_quo;
      rem       <= next_rem;
      div_cnt   <= next_div_cnt;
      idx       <= next_idx;
      dig       <= next_dig;
      val       <= next_val;
      invalid   <= next_invalid;
    end
  end

  apsf_fifo #(.W(CHAR_W), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (in_ready),
    .in_data_i   (ch),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // start-stop transmitter, line pair drive
  logic [9:0]  sh, next_sh;
  logic [3:0]  bits, next_bits;
  logic [12:0] bcnt, next_bcnt;
  logic        next_pos;

  always_comb begin
    pop       = (bits == '0) & fifo_valid;
    next_sh   = sh;
    next_bits = bits;
    next_bcnt = bcnt;
    if (pop) begin
      next_sh   = {1'b1, ^fifo_data, fifo_data, 1'b0}; // RQ10
      next_bits = 4'(UART_BITS);
      next_bcnt = '0;
    end else if (bits != '0) begin
      next_bcnt = bcnt + 13'h1;
      if (bcnt == 13'(BIT_CYC_P - 1)) begin
        next_bcnt = '0;
        next_sh   = {1'b1, sh[9:1]}; // RQ10
        next_bits = bits - 4'h1;
      end
    end
    if (zphase_output_select_i == APSF_SEL_PULSE) next_pos = zphase_pulse_i; // RQ5
    else next_pos = (next_bits != '0) ? next_sh[0] : 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh                <= '1;
      bits              <= '0;
      bcnt              <= '0;
      zphase_line_pos_o <= 1'b1;
      zphase_line_neg_o <= 1'b0;
      data_invalid_o    <= 1'b0;
    end else if (ce_i) begin
      sh                <= next_sh;
      bits              <= next_bits;
      bcnt              <= next_bcnt;
      zphase_line_pos_o <= next_pos; // RQ4
      zphase_line_neg_o <= ~next_pos; // RQ4
      data_invalid_o    <= next_invalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i iff ce_i); endclocking
  default disable iff (!rst_n_i);

  a_line_pair:   assert property (zphase_line_pos_o != zphase_line_neg_o) // RQ4
    else $error("line pair not complementary");
  a_head_char:   assert property (push && idx == IDX_HEAD |-> ch == CH_HEAD) // RQ1
    else $error("frame does not open with header");
  a_last_char:   assert property (push && idx == IDX_LAST // RQ1
                   |=> state == S_IDLE && ch == CH_HEAD)
    else $error("carriage return does not close frame");
  a_sign_char:   assert property (push && idx == IDX_SIGN // RQ2
                   |-> ch == (smp.neg ? CH_MINUS : CH_PLUS))
    else $error("bad sign character");
  // an overflowed geared frame may carry digits above nine
  a_digit_ok:    assert property (push && is_digit && !invalid // RQ3
                   |-> ch >= CH_ZERO && ch <= CH_ZERO + 7'h9)
    else $error("digit out of range");
  a_single_load: assert property (push && idx == IDX_DELIM // RQ3
                   |=> val == {1'b0, $past(smp.mag[14:0]), 2'b00})
    else $error("single-turn field not scaled by four");
  a_pulse_pass:  assert property (zphase_output_select_i == APSF_SEL_PULSE // RQ5
                   |=> zphase_line_pos_o == $past(zphase_pulse_i))
    else $error("pulse mode does not pass phase pulse");
  a_enc_pick:    assert property (state == S_IDLE && next_state == S_BUILD // RQ6
                   |=> smp.neg == $past(encoder_type_select_i ? abs_position_i[31]
                                                            : inc_position_i[31]))
    else $error("wrong position source");
  a_gear_steps:  assert property (state == S_IDLE && next_state == S_DIV // RQ7
                   |-> ##49 state == S_DIV ##1 state == S_BUILD)
    else $error("divider step count wrong");
  a_gear_flag:   assert property (state == S_IDLE && next_state == S_DIV // RQ8 RQ9
                   && (second_gear_select_i ? gear2_i.den > gear2_i.num
                                            : gear1_i.den > gear1_i.num)
                   |=> ##1 data_invalid_o)
    else $error("overflowing gear ratio not flagged");
  a_parity_bit:  assert property (pop |=> sh[8] == ^sh[7:1] && sh[0] == 1'b0) // RQ10
    else $error("bad parity or start bit");
  a_capture_hold: assert property (state == S_BUILD && next_state == S_BUILD // RQ11
                   |=> smp == $past(smp))
    else $error("sample changed mid frame");

  c_plain_frame:  cover property (push && idx == IDX_LAST && !invalid);
  c_geared_frame: cover property (state == S_DIV ##[1:60] state == S_BUILD);
  c_fifo_full:    cover property (push ##1 !in_ready);
  c_neg_sign:     cover property (push && idx == IDX_SIGN && smp.neg);
endmodule

// file: include/apsf_pkg.sv
// constants, types and timing for the position serial framer
//
// How it works
// RQ1: 16 chars: P, sign, 5 digits, comma, 7 digits, CR
// RQ2: second char is plus or minus sign
// RQ3: single-turn times four, seven decimal digits
// RQ4: logic 1 drives pos high, neg low
// RQ5: selector picks pulse, plain, alternate, geared
// RQ6: encoder type picks absolute or incremental
// RQ7: geared mode scales by reciprocal gear ratio
// RQ8: second gear select picks second pair
// RQ9: ratio below one overflows, data invalid
// RQ10: 9600 baud, 7E1, LSB first, 40 ms
// RQ11: both fields captured together per frame
package apsf_pkg;
  localparam int CLK_HZ     = 50_000_000;
  localparam int FRAME_MS   = 40;
  localparam int FRAME_CYC  = CLK_HZ / 1000 * FRAME_MS;
  localparam int BAUD_BPS   = 9600;
  localparam int BIT_CYC    = CLK_HZ / BAUD_BPS;
  localparam int FIFO_DEPTH = 8;
  localparam int CHAR_W     = 7;
  localparam int TURN_BITS  = 15;
  localparam int DIV_STEPS  = 48;
  localparam int UART_BITS  = 10;

  localparam logic [6:0] CH_HEAD  = 7'h50;
  localparam logic [6:0] CH_PLUS  = 7'h2b;
  localparam logic [6:0] CH_MINUS = 7'h2d;
  localparam logic [6:0] CH_DELIM = 7'h2c;
  localparam logic [6:0] CH_CR    = 7'h0d;
  localparam logic [6:0] CH_ZERO  = 7'h30;
  localparam logic [3:0] IDX_HEAD  = 4'h0;
  localparam logic [3:0] IDX_SIGN  = 4'h1;
  localparam logic [3:0] IDX_DELIM = 4'h7;
  localparam logic [3:0] IDX_LAST  = 4'hf;
  localparam logic [16:0] MULTI_MAX = 17'h1869f;

  typedef enum logic [1:0] {
    APSF_SEL_PULSE,
    APSF_SEL_PLAIN,
    APSF_SEL_GEARED,
    APSF_SEL_ALT
  } apsf_sel_t;

  typedef struct packed {
    logic [15:0] num;
    logic [15:0] den;
  } apsf_gear_t;

  typedef struct packed {
    logic        neg;
    logic [31:0] mag;
  } apsf_pos_t;
endpackage

// file: testbench/apsf_rx_model.sv
// receiver model of the upstream controller on the line pair
`timescale 1ns/1ps
module apsf_rx_model #(
  parameter int BIT_CYC_P = 4
) (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  line_pos_i,
  input  wire logic  line_neg_i,
  output logic       char_valid_o,
  output logic [6:0] char_o,
  output logic       char_err_o
);
  logic       busy;
  logic       bad;
  int         cnt;
  int         bitn;
  logic [9:0] sh;
  //////////////////////////////////////////////////////////////////////////////
  // sample mid-bit; the line idles high, so a low level opens a character
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      bad <= 1'b0;
      cnt <= 0;
      bitn <= 0;
      sh <= '0;
      char_valid_o <= 1'b0;
      char_o <= '0;
      char_err_o <= 1'b0;
    end else begin
      char_valid_o <= 1'b0;
      if (!busy) begin
        if (line_pos_i === 1'b0) begin
          busy <= 1'b1;
          cnt <= BIT_CYC_P / 2 - 1;
          bitn <= 0;
          bad <= 1'b0;
        end
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end else begin
        cnt <= BIT_CYC_P - 1;
        bitn <= bitn + 1;
        sh[bitn] <= line_pos_i;
        if (line_neg_i !== ~line_pos_i) bad <= 1'b1;
        if (bitn == 9) begin
          busy <= 1'b0;
          char_valid_o <= 1'b1;
          char_o <= sh[7:1];
          char_err_o <= bad | (line_neg_i !== ~line_pos_i) | sh[0] | ~line_pos_i
                        | (^sh[8:1]);
        end
      end
    end
  end
endmodule

// file: testbench/tb_abs_position_serial_framer.sv
// self-checking bench for the position serial framer
`timescale 1ns/1ps
module tb_abs_position_serial_framer;
  import apsf_pkg::*;
  localparam int FRAME_P = 3000;
  localparam int BIT_P   = 4;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  apsf_sel_t   sel       = APSF_SEL_PLAIN;
  logic        enc_abs   = 1'b1;
  logic [31:0] abs_pos   = 32'h0;
  logic [31:0] inc_pos   = 32'h0;
  logic        pulse     = 1'b0;
  logic        gear_sel  = 1'b0;
  logic        ce        = 1'b1;
  apsf_gear_t  gear1     = '{num: 16'h0005, den: 16'h0003};
  apsf_gear_t  gear2     = '{num: 16'h0007, den: 16'h0002};
  logic        line_pos;
  logic        line_neg;
  logic        invalid;
  logic        rx_valid;
  logic        rx_err;
  logic [6:0]  rx_char;
  logic [15:0] lfsr      = 16'h951a;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  //////////////////////////////////////////////////////////////////////////////
  // short frame and bit counts keep the run small
  apsf_framer #(.FRAME_CYC_P(FRAME_P), .BIT_CYC_P(BIT_P)) u_apsf_framer (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .zphase_output_select_i(sel), .encoder_type_select_i(enc_abs),
    .abs_position_i(abs_pos), .inc_position_i(inc_pos), .zphase_pulse_i(pulse),
    .second_gear_select_i(gear_sel), .gear1_i(gear1), .gear2_i(gear2),
    .zphase_line_pos_o(line_pos), .zphase_line_neg_o(line_neg), .data_invalid_o(invalid));
  apsf_rx_model #(.BIT_CYC_P(BIT_P)) u_apsf_rx_model (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .line_pos_i(line_pos), .line_neg_i(line_neg),
    .char_valid_o(rx_valid), .char_o(rx_char), .char_err_o(rx_err));
  //////////////////////////////////////////////////////////////////////////////
  always #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic rnd32(output logic [31:0] r);
    lfsr = step(lfsr);
    r[15:0] = lfsr;
    lfsr = step(lfsr);
    r[31:16] = lfsr;
  endtask
  task automatic check_char(input logic [6:0] e, input logic [6:0] g, input int k);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: char %0d exp %h got %h", $time, k, e, g);
    end
  endtask
  task automatic check_flag(input logic e, input logic g, input string what);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: %s exp %b got %b", $time, what, e, g);
    end
  endtask
  // wait bound covers the idle gap between frames
  task automatic get_char(output logic [6:0] c);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end while (rx_valid !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      mismatches++;
      end_of_test();
    end
    c = rx_char;
    check_flag(1'b0, rx_err, "char framing");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // one frame per case; inputs change right after a carriage return
  task automatic run_case(input int i);
    logic [31:0] p;
    logic [6:0]  e[16];
    logic [6:0]  c;
    longint      mag;
    longint      m;
    longint      s;
    longint      d;
    apsf_gear_t  g;
    #1;
    sel = (i == 2) ? APSF_SEL_ALT : (i < 2 ? APSF_SEL_PLAIN : APSF_SEL_GEARED);
    enc_abs = (i != 1 && i != 4);
    gear_sel = (i == 4);
    gear1 = (i == 5) ? '{num: 16'h0002, den: 16'h0009} : '{num: 16'h0005, den: 16'h0003};
    rnd32(abs_pos);
    rnd32(inc_pos);
    abs_pos[31] = i[0];
    p = enc_abs ? abs_pos : inc_pos;
    g = gear_sel ? gear2 : gear1;
    mag = longint'(signed'(p));
    if (mag < 0) mag = -mag;
    if (sel == APSF_SEL_GEARED) mag = (mag * longint'(g.den) / longint'(g.num)) & 64'hffffffff;
    m = mag >> 15;
    s = (mag & 64'h7fff) * 4;
    e[0] = CH_HEAD;
    e[1] = p[31] ? CH_MINUS : CH_PLUS;
    e[7] = CH_DELIM;
    e[15] = CH_CR;
    d = 10000;
    for (int j = 2; j < 7; j++) begin
      e[j] = 7'(CH_ZERO + (m / d) % 10);
      d = d / 10;
    end
    d = 1000000;
    for (int j = 8; j < 15; j++) begin
      e[j] = 7'(CH_ZERO + (s / d) % 10);
      d = d / 10;
    end
    for (int k = 0; k < 16; k++) begin
      get_char(c);
      if (k == 0) begin
        #1;
        rnd32(abs_pos);
        rnd32(inc_pos);
      end
      if (i != 5) check_char(e[k], c, k);
    end
    check_flag(1'(i == 5), invalid, "invalid flag");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [6:0] c;
    logic       exp_pos;
    repeat (8) @(posedge ref_clk_i);
    #2;
    rst_n_i = 1'b1;
    do get_char(c); while (c !== CH_CR);
    for (int i = 0; i < 6; i++) run_case(i);
    #1;
    sel = APSF_SEL_PULSE;
    repeat (2) @(posedge ref_clk_i);
    // spans a frame tick; in pulse mode the line follows only the pulse input
    // ce drops one cycle in sixteen; the line must hold then
    for (int k = 0; k < 3500; k++) begin
      @(posedge ref_clk_i);
      #1;
      if (ce) exp_pos = pulse;
      check_flag(exp_pos, line_pos, "pulse pos");
      check_flag(~exp_pos, line_neg, "pulse neg");
      #1;
      lfsr = step(lfsr);
      pulse = lfsr[0];
      ce = ((k % 16) != 15);
    end
    end_of_test();
  end
endmodule
